//--- src/ldc_map.svh
`ifndef LDC_MAP_SVH
`define LDC_MAP_SVH
// Register byte addresses.
`define LDC_OFS_SCALE 8'h63
`define LDC_OFS_SHAPE 8'h65
`define LDC_OFS_SOURCE 8'h66
`define LDC_OFS_TRIM_A 8'h67
`define LDC_OFS_TRIM_B 8'h68
// Field positions in the shape byte.
`define LDC_SLOPE_MSB 7
`define LDC_SLOPE_LSB 5
`define LDC_RES_MSB 4
`define LDC_RES_LSB 3
`define LDC_DITH_MSB 2
`define LDC_DITH_LSB 0
// Field positions in the source byte.
`define LDC_SWITCH_MSB 6
`define LDC_SWITCH_LSB 4
`define LDC_RSEL_BIT 3
`define LDC_SPLIT_BIT 2
`define LDC_SRC_MSB 1
`define LDC_SRC_LSB 0
// Field positions in the trim bytes and the scale byte.
`define LDC_TRIM_HI_MSB 7
`define LDC_TRIM_HI_LSB 4
`define LDC_TRIM_LO_MSB 3
`define LDC_TRIM_LO_LSB 0
`define LDC_SCALE_MSB 6
`define LDC_SCALE_LSB 4
`define LDC_HYB_BIT 0
// Reset value of every configuration byte.
`define LDC_RESET_BYTE 8'h00
`endif

//--- src/ldc_pkg.sv
package ldc_pkg;
  // Brightness source choices.
  typedef enum logic [1:0] {
    LDC_SRC_PIN_DUTY = 2'b00,
    LDC_SRC_PRODUCT = 2'b01,
    LDC_SRC_REGISTER = 2'b10,
    LDC_SRC_DIRECT = 2'b11
  } ldc_src_t;
  typedef logic [7:0] ldc_byte_t;
  // Trim in tenths of a percent, signed.
  typedef logic signed [7:0] ldc_trim_t;
  // Shared by all four sinks, so it lives here once.
  function automatic ldc_trim_t ldc_trim_decode(input logic [3:0] code);
    ldc_trim_t t;
    t = 8'h00;
    unique case (code)
      4'h0: t = 8'h41;
      4'h1: t = 8'h38;
      4'h2: t = 8'h2f;
      4'h3: t = 8'h25;
      4'h4: t = 8'h1c;
      4'h5: t = 8'h13;
      4'h6: t = 8'h09;
      4'h7: t = 8'h00;
      4'h8: t = 8'hf7;
      4'h9: t = 8'hed;
      4'ha: t = 8'he4;
      4'hb: t = 8'hdb;
      4'hc: t = 8'hd1;
      4'hd: t = 8'hc8;
      4'he: t = 8'hbf;
      4'hf: t = 8'hb6;
    endcase
    return t;
  endfunction
endpackage

//--- src/ldc_cfg_if.sv
`timescale 1ns/1ns
// Carries the stored configuration bytes from the bank to the decoder.
interface ldc_cfg_if;
  logic [7:0] scaleCfg;
  logic [7:0] shapeCfg;
  logic [7:0] sourceCfg;
  logic [7:0] trimA;
  logic [7:0] trimB;
  modport bank (output scaleCfg, output shapeCfg, output sourceCfg, output trimA,
    output trimB);
  modport dec (input scaleCfg, input shapeCfg, input sourceCfg, input trimA,
    input trimB);
endinterface

//--- src/ldc_decode.sv
`timescale 1ns/1ns
`include "ldc_map.svh"
// Turns the stored bytes into control values; purely combinational.
module ldc_decode (
  ldc_cfg_if.dec cfg,
  input wire logic extSyncUsed,
  output logic [10:0] slopeMilli,
  output logic [5:0] pwmClockMhz,
  output logic [2:0] ditherBits,
  output logic [9:0] switchPermille,
  output logic [7:0] fullScaleMa,
  output logic hybridEnable
);
  import ldc_pkg::*;
  logic [2:0] slopeCode; // Raw slope gain code.
  logic [2:0] switchCode; // Raw switch point code.
  logic [2:0] scaleCode; // Raw full scale code.
  assign slopeCode = cfg.shapeCfg[`LDC_SLOPE_MSB:`LDC_SLOPE_LSB];
  assign switchCode = cfg.sourceCfg[`LDC_SWITCH_MSB:`LDC_SWITCH_LSB];
  assign scaleCode = cfg.scaleCfg[`LDC_SCALE_MSB:`LDC_SCALE_LSB];
  assign hybridEnable = cfg.scaleCfg[`LDC_HYB_BIT];
  // Decode tables; hybrid fields go neutral when hybrid dimming is off.
  always_comb begin
    slopeMilli = 11'h3e8;
    switchPermille = 10'h000;
    if (hybridEnable) begin
      unique case (slopeCode)
        3'h0: slopeMilli = 11'h3e8;
        3'h1: slopeMilli = 11'h3ff;
        3'h2: slopeMilli = 11'h417;
        3'h3: slopeMilli = 11'h42e;
        3'h4: slopeMilli = 11'h446;
        3'h5: slopeMilli = 11'h45d;
        3'h6: slopeMilli = 11'h475;
        3'h7: slopeMilli = 11'h48c;
      endcase
      unique case (switchCode)
        3'h0: switchPermille = 10'h1f4;
        3'h1: switchPermille = 10'h196;
        3'h2: switchPermille = 10'h139;
        3'h3: switchPermille = 10'h0fa;
        3'h4: switchPermille = 10'h0db;
        3'h5: switchPermille = 10'h0bc;
        3'h6: switchPermille = 10'h09c;
        3'h7: switchPermille = 10'h07d;
      endcase
    end
  end
  // Multiplier clock, dither depth and full scale current.
  always_comb begin
    pwmClockMhz = 6'h00;
    if (!extSyncUsed) begin
      unique case (cfg.shapeCfg[`LDC_RES_MSB:`LDC_RES_LSB])
        2'h0: pwmClockMhz = 6'h05;
        2'h1: pwmClockMhz = 6'h0a;
        2'h2: pwmClockMhz = 6'h14;
        2'h3: pwmClockMhz = 6'h28;
      endcase
    end
    ditherBits = cfg.shapeCfg[`LDC_DITH_MSB] ? 3'h4 :
      cfg.shapeCfg[`LDC_DITH_MSB:`LDC_DITH_LSB];
    fullScaleMa = 8'h00;
    if (!cfg.sourceCfg[`LDC_RSEL_BIT]) begin
      unique case (scaleCode)
        3'h0: fullScaleMa = 8'h19;
        3'h1: fullScaleMa = 8'h1e;
        3'h2: fullScaleMa = 8'h32;
        3'h3: fullScaleMa = 8'h3c;
        3'h4: fullScaleMa = 8'h50;
        3'h5: fullScaleMa = 8'h64;
        3'h6: fullScaleMa = 8'h78;
        3'h7: fullScaleMa = 8'h96;
      endcase
    end
  end
endmodule // ldc_decode

//--- src/ldc_config_bank.sv
`timescale 1ns/1ns
`include "ldc_map.svh"
// Operation
// - Slope gain 1.000 to 1.164 by code.
// - Resolution field picks 5/10/20/40 MHz clock.
// - Dither off, 1-3 bits, 1XX four bits.
// - Hybrid switch point 50.0% down to 12.5%.
// - Scale bit picks internal field or resistor.
// - Small transistor below 1/16 when enabled.
// - Source field picks duty, product, register, direct.
// - Sink 1 signed trim, low nibble.
// - Sink 2 trim, high nibble, same byte.
// - Sink 3 trim, low nibble, next byte.
// - Sink 4 trim, high nibble, next byte.
// - Internal scale field sets maximum current.
// - Hybrid enable bit; off means PWM only.
module ldc_config_bank #(
  parameter int DUTY_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire ldc_pkg::ldc_byte_t wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  output ldc_pkg::ldc_byte_t rdData,
  input wire logic pwmIn,
  input wire logic [DUTY_W-1:0] pwmDuty,
  input wire logic [DUTY_W-1:0] brightness,
  input wire logic [DUTY_W-1:0] sinkSetting,
  input wire logic extSyncUsed,
  output logic [DUTY_W-1:0] brightnessLevel,
  output logic directPwm,
  output logic directMode,
  output logic hybridEnable,
  output logic [10:0] slopeMilli,
  output logic [9:0] switchPermille,
  output logic [5:0] pwmClockMhz,
  output logic [2:0] ditherBits,
  output logic currentSetResistorSelect,
  output logic [7:0] fullScaleCurrentMa,
  output logic smallTransistorSelect,
  output ldc_pkg::ldc_trim_t sink1Trim,
  output ldc_pkg::ldc_trim_t sink2Trim,
  output ldc_pkg::ldc_trim_t sink3Trim,
  output ldc_pkg::ldc_trim_t sink4Trim
);
  import ldc_pkg::*;

  // ----------------------------------------
  // Storage and decode wiring
  // ----------------------------------------

  // Stored bytes travel to the decoder through this interface.
  ldc_cfg_if cfg ();
  // Decoder results, registered below before they leave.
  logic [10:0] decSlope;
  // Decoded switch point in permille.
  logic [9:0] decSwitch;
  // Decoded multiplier clock in MHz.
  logic [5:0] decClock;
  // Decoded dither depth in bits.
  logic [2:0] decDither;
  // Decoded full scale current in mA.
  logic [7:0] decScale;
  // Decoded hybrid dimming enable.
  logic decHybrid;
  // Brightness source as an enumerated value.
  ldc_src_t srcSel;
  // Product of pin duty and brightness register, full width.
  logic [2*DUTY_W-1:0] dutyProduct;
  // Next value of the brightness output.
  logic [DUTY_W-1:0] next_brightnessLevel;
  // Next value of the read data.
  ldc_byte_t next_rdData;
  // Settings below this value count as under 1/16 of full scale.
  localparam logic [DUTY_W-1:0] SIXTEENTH = DUTY_W'(1) << (DUTY_W - 4);

  // ----------------------------------------
  // Register writes
  // ----------------------------------------

  // The scale byte holds the full scale code and hybrid enable only.
  // Other bits of that byte are not stored, so they cannot leak in.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg.scaleCfg <= `LDC_RESET_BYTE;
    end else if (wrEn && addr == `LDC_OFS_SCALE) begin
      cfg.scaleCfg <= 8'h00;
      cfg.scaleCfg[`LDC_SCALE_MSB:`LDC_SCALE_LSB] <=
        wrData[`LDC_SCALE_MSB:`LDC_SCALE_LSB];
      cfg.scaleCfg[`LDC_HYB_BIT] <= wrData[`LDC_HYB_BIT];
    end
  end

  // The shape byte is stored whole; every bit is a live field.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg.shapeCfg <= `LDC_RESET_BYTE;
    end else if (wrEn && addr == `LDC_OFS_SHAPE) begin
      cfg.shapeCfg <= wrData;
    end
  end

  // The source byte drops its reserved top bit on the way in.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg.sourceCfg <= `LDC_RESET_BYTE;
    end else if (wrEn && addr == `LDC_OFS_SOURCE) begin
      cfg.sourceCfg <= {1'b0, wrData[6:0]};
    end
  end

  // First trim pair, sinks 1 and 2.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg.trimA <= `LDC_RESET_BYTE;
    end else if (wrEn && addr == `LDC_OFS_TRIM_A) begin
      cfg.trimA <= wrData;
    end
  end

  // Second trim pair, sinks 3 and 4.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg.trimB <= `LDC_RESET_BYTE;
    end else if (wrEn && addr == `LDC_OFS_TRIM_B) begin
      cfg.trimB <= wrData;
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------

  // Read data come from stored state; an unmapped address reads zero.
  always_comb begin
    next_rdData = 8'h00;
    unique case (addr)
      `LDC_OFS_SCALE: next_rdData = cfg.scaleCfg;
      `LDC_OFS_SHAPE: next_rdData = cfg.shapeCfg;
      `LDC_OFS_SOURCE: next_rdData = cfg.sourceCfg;
      `LDC_OFS_TRIM_A: next_rdData = cfg.trimA;
      `LDC_OFS_TRIM_B: next_rdData = cfg.trimB;
      default: next_rdData = 8'h00;
    endcase
  end

  // Read data stand for exactly the one cycle after the strobe.
  // Outside that cycle the bus shows zero, which keeps stale data off it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= 8'h00;
    end else if (rdEn) begin
      rdData <= next_rdData;
    end else begin
      rdData <= 8'h00;
    end
  end

  // ----------------------------------------
  // Field decoding
  // ----------------------------------------

  // Table lookups other than the trims live in the decoder so this file keeps the datapath.
  ldc_decode u_decode (
    .cfg(cfg.dec),
    .extSyncUsed(extSyncUsed),
    .slopeMilli(decSlope),
    .pwmClockMhz(decClock),
    .ditherBits(decDither),
    .switchPermille(decSwitch),
    .fullScaleMa(decScale),
    .hybridEnable(decHybrid)
  );

  // Hybrid dimming values; zero in reset, then neutral while hybrid dimming is off.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hybridEnable <= 1'b0;
      slopeMilli <= 11'h000;
      switchPermille <= 10'h000;
    end else begin
      hybridEnable <= decHybrid;
      slopeMilli <= decSlope;
      switchPermille <= decSwitch;
    end
  end

  // PWM generator clock and dither depth.
  // A clock of zero tells the generator to follow the external sync.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwmClockMhz <= 6'h00;
      ditherBits <= 3'h0;
    end else begin
      pwmClockMhz <= decClock;
      ditherBits <= decDither;
    end
  end

  // ----------------------------------------
  // Current scale and transistor choice
  // ----------------------------------------

  // Full scale reads zero while the external resistor sets the scale,
  // so the sinks never mix the two sources.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      currentSetResistorSelect <= 1'b0;
      fullScaleCurrentMa <= 8'h00;
    end else begin
      currentSetResistorSelect <= cfg.sourceCfg[`LDC_RSEL_BIT];
      fullScaleCurrentMa <= decScale;
    end
  end

  // The small transistor only helps accuracy at low current; above
  // 1/16 of full scale it would saturate, so the large one takes over.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      smallTransistorSelect <= 1'b0;
    end else begin
      smallTransistorSelect <= cfg.sourceCfg[`LDC_SPLIT_BIT] &&
        (sinkSetting < SIXTEENTH);
    end
  end

  // ----------------------------------------
  // Brightness source
  // ----------------------------------------

  // Enumerated view of the source field.
  assign srcSel = ldc_src_t'(cfg.sourceCfg[`LDC_SRC_MSB:`LDC_SRC_LSB]);
  // Full product; the top half is the scaled brightness.
  assign dutyProduct = pwmDuty * brightness;

  // Choose the brightness value for the sinks.
  // In direct mode the duty path holds zero and the pin is passed on.
  always_comb begin
    next_brightnessLevel = '0;
    unique case (srcSel)
      LDC_SRC_PIN_DUTY: next_brightnessLevel = pwmDuty;
      LDC_SRC_PRODUCT: next_brightnessLevel = dutyProduct[2*DUTY_W-1:DUTY_W];
      LDC_SRC_REGISTER: next_brightnessLevel = brightness;
      LDC_SRC_DIRECT: next_brightnessLevel = '0;
    endcase
  end

  // Registered brightness and direct pass-through.
  // The pass-through costs one clock of delay on the pin; at 8 ns this
  // is far below any PWM period the sinks can follow.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      brightnessLevel <= '0;
      directMode <= 1'b0;
      directPwm <= 1'b0;
    end else begin
      brightnessLevel <= next_brightnessLevel;
      directMode <= (srcSel == LDC_SRC_DIRECT);
      directPwm <= (srcSel == LDC_SRC_DIRECT) && pwmIn;
    end
  end

  // ----------------------------------------
  // Per-sink current trim
  // ----------------------------------------

  // Trim values in signed tenths of a percent, one per sink.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sink1Trim <= 8'h00;
      sink2Trim <= 8'h00;
      sink3Trim <= 8'h00;
      sink4Trim <= 8'h00;
    end else begin
      sink1Trim <= ldc_trim_decode(cfg.trimA[`LDC_TRIM_LO_MSB:`LDC_TRIM_LO_LSB]);
      sink2Trim <= ldc_trim_decode(cfg.trimA[`LDC_TRIM_HI_MSB:`LDC_TRIM_HI_LSB]);
      sink3Trim <= ldc_trim_decode(cfg.trimB[`LDC_TRIM_LO_MSB:`LDC_TRIM_LO_LSB]);
      sink4Trim <= ldc_trim_decode(cfg.trimB[`LDC_TRIM_HI_MSB:`LDC_TRIM_HI_LSB]);
    end
  end
endmodule // ldc_config_bank

//--- verif/ldc_exp.svh
// Expected decodes, kept apart from the design's own tables on purpose.
// Both the bench and the checker include this file, so it carries no guard.
// With a guard, the second module to include it would get no functions.
function automatic logic [7:0] expTrim(input logic [3:0] c);
  logic [7:0] t [16];
  t = '{8'h41, 8'h38, 8'h2f, 8'h25, 8'h1c, 8'h13, 8'h09, 8'h00,
    8'hf7, 8'hed, 8'he4, 8'hdb, 8'hd1, 8'hc8, 8'hbf, 8'hb6};
  return t[c];
endfunction
// Slope gain in thousandths.
function automatic logic [10:0] expSlope(input logic [2:0] c);
  logic [10:0] t [8];
  t = '{11'h3e8, 11'h3ff, 11'h417, 11'h42e, 11'h446, 11'h45d, 11'h475, 11'h48c};
  return t[c];
endfunction
// Hybrid switch point in tenths of a percent.
function automatic logic [9:0] expSwitch(input logic [2:0] c);
  logic [9:0] t [8];
  t = '{10'h1f4, 10'h196, 10'h139, 10'h0fa, 10'h0db, 10'h0bc, 10'h09c, 10'h07d};
  return t[c];
endfunction
// Full-scale current in milliamps.
function automatic logic [7:0] expFull(input logic [2:0] c);
  logic [7:0] t [8];
  t = '{8'h19, 8'h1e, 8'h32, 8'h3c, 8'h50, 8'h64, 8'h78, 8'h96};
  return t[c];
endfunction
// The external sync takes the generator clock away, so it reads zero then.
function automatic logic [5:0] expClock(input logic [1:0] c, input logic ext);
  return ext ? 6'h00 : (6'h05 << c);
endfunction
// Any code with the top bit set means four bits.
function automatic logic [2:0] expDither(input logic [2:0] c);
  return c[2] ? 3'h4 : c;
endfunction

//--- verif/ldc_config_bank_chk.sv
`timescale 1ns/1ns
// Port-level watcher for the configuration bank.
module ldc_config_bank_chk #(
  parameter int DUTY_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire ldc_pkg::ldc_byte_t wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  input wire ldc_pkg::ldc_byte_t rdData,
  input wire logic pwmIn,
  input wire logic [DUTY_W-1:0] sinkSetting,
  input wire logic extSyncUsed,
  input wire logic directPwm,
  input wire logic directMode,
  input wire logic hybridEnable,
  input wire logic [10:0] slopeMilli,
  input wire logic [9:0] switchPermille,
  input wire logic [5:0] pwmClockMhz,
  input wire logic [2:0] ditherBits,
  input wire logic currentSetResistorSelect,
  input wire logic [7:0] fullScaleCurrentMa,
  input wire logic smallTransistorSelect,
  input wire ldc_pkg::ldc_trim_t sink1Trim,
  input wire ldc_pkg::ldc_trim_t sink2Trim,
  input wire ldc_pkg::ldc_trim_t sink3Trim,
  input wire ldc_pkg::ldc_trim_t sink4Trim
);
  import ldc_pkg::*;
  `include "ldc_exp.svh"
  `include "ldc_map.svh"
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // A write is only judged when no second write to the byte follows it.
  wire scaleWr = wrEn && addr == `LDC_OFS_SCALE;
  wire shapeWr = wrEn && addr == `LDC_OFS_SHAPE;
  wire sourceWr = wrEn && addr == `LDC_OFS_SOURCE;
  wire trimAWr = wrEn && addr == `LDC_OFS_TRIM_A;
  wire trimBWr = wrEn && addr == `LDC_OFS_TRIM_B;
  property p_slope; shapeWr ##1 !shapeWr |=>
    !hybridEnable || slopeMilli == expSlope($past(wrData[7:5], 2)); endproperty
  a_slope: assert property (p_slope) else $error("slope gain mismatch"); // gain
  property p_clock; shapeWr ##1 !shapeWr |=>
    pwmClockMhz == expClock($past(wrData[4:3], 2), $past(extSyncUsed)); endproperty
  a_clock: assert property (p_clock) else $error("pwm clock mismatch"); // clock
  property p_dither; shapeWr ##1 !shapeWr |=>
    ditherBits == expDither($past(wrData[2:0], 2)); endproperty
  a_dither: assert property (p_dither) else $error("dither mismatch"); // depth
  property p_switch; sourceWr ##1 !sourceWr |=>
    !hybridEnable || switchPermille == expSwitch($past(wrData[6:4], 2)); endproperty
  a_switch: assert property (p_switch) else $error("switch point mismatch"); // point
  property p_rsel; currentSetResistorSelect |-> fullScaleCurrentMa == 8'h00; endproperty
  a_rsel: assert property (p_rsel) else $error("resistor scale mismatch"); // resistor
  property p_split; smallTransistorSelect |-> $past(sinkSetting) < 16'h1000; endproperty
  a_split: assert property (p_split) else $error("small transistor misuse"); // split
  property p_direct; directPwm == (directMode && $past(pwmIn)); endproperty
  a_direct: assert property (p_direct) else $error("direct pwm mismatch"); // direct
  property p_trimA; trimAWr ##1 !trimAWr |=> sink1Trim == expTrim($past(wrData[3:0], 2))
    && sink2Trim == expTrim($past(wrData[7:4], 2)); endproperty
  a_trimA: assert property (p_trimA) else $error("first trim mismatch"); // trim
  property p_trimB; trimBWr ##1 !trimBWr |=> sink3Trim == expTrim($past(wrData[3:0], 2))
    && sink4Trim == expTrim($past(wrData[7:4], 2)); endproperty
  a_trimB: assert property (p_trimB) else $error("second trim mismatch"); // trim
  property p_scale; scaleWr ##1 !scaleWr |=> currentSetResistorSelect ||
    fullScaleCurrentMa == expFull($past(wrData[6:4], 2)); endproperty
  a_scale: assert property (p_scale) else $error("full scale mismatch"); // scale
  property p_hyb; $past(rst_n) && !hybridEnable |->
    slopeMilli == 11'h3e8 && switchPermille == 10'h000; endproperty
  a_hyb: assert property (p_hyb) else $error("pwm-only mode mismatch"); // hybrid
  property p_reserved; rdEn && addr == `LDC_OFS_SOURCE |=> rdData[7] == 1'b0; endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set"); // reserved
endmodule // ldc_config_bank_chk

//--- verif/ldc_config_bank_tb.sv
`timescale 1ns/1ns
// Random and corner stimulus for the configuration bank.
module ldc_config_bank_tb;
  import ldc_pkg::*;
  `include "ldc_map.svh"
  `include "ldc_exp.svh"
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wrData = 8'h00;
  logic wrEn = 1'b0;
  logic rdEn = 1'b0;
  logic pwmIn = 1'b0;
  logic extSyncUsed = 1'b0;
  logic [15:0] pwmDuty = 16'h0000, brightness = 16'h0000, sinkSetting = 16'h0000;
  ldc_byte_t rdData;
  logic [15:0] brightnessLevel;
  logic directPwm, directMode, hybridEnable, currentSetResistorSelect, smallTransistorSelect;
  logic [10:0] slopeMilli;
  logic [9:0] switchPermille;
  logic [5:0] pwmClockMhz;
  logic [2:0] ditherBits;
  logic [7:0] fullScaleCurrentMa;
  ldc_trim_t sink1Trim, sink2Trim, sink3Trim, sink4Trim;
  // Shadow copies of what software last wrote.
  logic [7:0] cfgScale = 8'h00, cfgShape = 8'h00, cfgSource = 8'h00;
  logic [7:0] cfgTrimA = 8'h00, cfgTrimB = 8'h00;
  integer seed = 32'h5929c802;
  int bad_count = 0;
  int comparisons = 0;
  always #4 clk = ~clk;
  ldc_config_bank ldc_config_bank_i (.clk(clk), .rst_n(rst_n), .addr(addr), .wrData(wrData),
    .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .pwmIn(pwmIn), .pwmDuty(pwmDuty),
    .brightness(brightness), .sinkSetting(sinkSetting), .extSyncUsed(extSyncUsed),
    .brightnessLevel(brightnessLevel), .directPwm(directPwm), .directMode(directMode),
    .hybridEnable(hybridEnable), .slopeMilli(slopeMilli), .switchPermille(switchPermille),
    .pwmClockMhz(pwmClockMhz), .ditherBits(ditherBits),
    .currentSetResistorSelect(currentSetResistorSelect),
    .fullScaleCurrentMa(fullScaleCurrentMa), .smallTransistorSelect(smallTransistorSelect),
    .sink1Trim(sink1Trim), .sink2Trim(sink2Trim), .sink3Trim(sink3Trim), .sink4Trim(sink4Trim));
  // Narrow values are widened by the caller; trims go in as part-selects to stay unsigned.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrEn <= 1'b1;
    @(posedge clk);
    wrEn <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are sampled there.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    #1;
    chk(rdData, e);
  endtask
  task automatic checkOutputs();
    logic hyb;
    logic [1:0] src;
    logic [31:0] prod;
    logic [15:0] lvl;
    hyb = cfgScale[0];
    src = cfgSource[1:0];
    prod = pwmDuty * brightness;
    case (src)
      2'h0: lvl = pwmDuty;
      2'h1: lvl = prod[31:16];
      2'h2: lvl = brightness;
      default: lvl = 16'h0000;
    endcase
    chk(brightnessLevel, lvl); // level
    chk(directPwm, (src == 2'h3) & pwmIn); // pass
    chk(directMode, src == 2'h3); // mode
    chk(hybridEnable, hyb); // enable
    chk(slopeMilli, hyb ? expSlope(cfgShape[7:5]) : 11'h3e8); // gain
    chk(switchPermille, hyb ? expSwitch(cfgSource[6:4]) : 10'h000); // point
    chk(pwmClockMhz, expClock(cfgShape[4:3], extSyncUsed)); // clock
    chk(ditherBits, expDither(cfgShape[2:0])); // depth
    chk(currentSetResistorSelect, cfgSource[3]); // select
    chk(fullScaleCurrentMa, cfgSource[3] ? 8'h00 : expFull(cfgScale[6:4])); // ma
    chk(smallTransistorSelect, cfgSource[2] && sinkSetting < 16'h1000); // split
    chk(sink1Trim[7:0], expTrim(cfgTrimA[3:0])); // trim
    chk(sink2Trim[7:0], expTrim(cfgTrimA[7:4])); // trim
    chk(sink3Trim[7:0], expTrim(cfgTrimB[3:0])); // trim
    chk(sink4Trim[7:0], expTrim(cfgTrimB[7:4])); // trim
  endtask
  task automatic end_of_test();
    $display("comparisons=%0d mismatches=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // A hang counts as a mismatch and ends through the same closing task.
  initial begin
    #200000;
    bad_count++;
    end_of_test();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    checkOutputs();
    // The first eight passes walk the shape and source codes, the first sixteen walk trim B; the rest are random.
    for (int i = 0; i < 48; i++) begin
      @(posedge clk);
      cfgScale = 8'($random(seed));
      cfgShape = (i < 8) ? {i[2:0], i[1:0], i[2:0]} : 8'($random(seed));
      cfgSource = (i < 8) ? {i[0], i[2:0], i[1:0], i[1:0]} : 8'($random(seed));
      cfgTrimA = 8'($random(seed));
      cfgTrimB = (i < 16) ? {i[3:0], ~i[3:0]} : 8'($random(seed));
      pwmDuty <= 16'($random(seed));
      brightness <= 16'($random(seed));
      pwmIn <= 1'($random(seed));
      extSyncUsed <= 1'($random(seed));
      // The 1/16 boundary is hit from both sides.
      sinkSetting <= (i % 3 == 0) ? 16'h0fff : (i % 3 == 1) ? 16'h1000 : 16'($random(seed));
      wr(`LDC_OFS_SCALE, cfgScale);
      wr(`LDC_OFS_SHAPE, cfgShape);
      wr(`LDC_OFS_SOURCE, cfgSource);
      wr(`LDC_OFS_TRIM_A, cfgTrimA);
      wr(`LDC_OFS_TRIM_B, cfgTrimB);
      // An unmapped write must not disturb the stored bytes read below.
      wr((i % 2) ? 8'h64 : 8'h69, 8'($random(seed)));
      rd((i % 2) ? 8'h64 : 8'h69, 8'h00);
      rd(`LDC_OFS_SCALE, cfgScale & 8'h71); // readback
      rd(`LDC_OFS_SHAPE, cfgShape); // readback
      rd(`LDC_OFS_SOURCE, cfgSource & 8'h7f); // reserved
      rd(`LDC_OFS_TRIM_A, cfgTrimA); // readback
      rd(`LDC_OFS_TRIM_B, cfgTrimB); // readback
      repeat (2) @(posedge clk);
      #1;
      checkOutputs();
    end
    // A second reset in mid-run clears every byte again.
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    #1;
    chk(slopeMilli, 16'h0000); // reset
    chk(fullScaleCurrentMa, 16'h0000); // reset
    // Release on a rising edge, like every other input of the bench.
    @(posedge clk);
    rst_n <= 1'b1;
    {cfgScale, cfgShape, cfgSource, cfgTrimA, cfgTrimB} = 40'h0;
    repeat (2) @(posedge clk);
    #1;
    checkOutputs();
    rd(`LDC_OFS_SOURCE, 8'h00); // cleared
    end_of_test();
  end
endmodule // ldc_config_bank_tb
bind ldc_config_bank ldc_config_bank_chk #(.DUTY_W(DUTY_W)) ldc_config_bank_chk_i (
  .clk(clk), .rst_n(rst_n), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn),
  .rdData(rdData), .pwmIn(pwmIn), .sinkSetting(sinkSetting), .extSyncUsed(extSyncUsed),
  .directPwm(directPwm), .directMode(directMode), .hybridEnable(hybridEnable),
  .slopeMilli(slopeMilli), .switchPermille(switchPermille), .pwmClockMhz(pwmClockMhz),
  .ditherBits(ditherBits), .currentSetResistorSelect(currentSetResistorSelect),
  .fullScaleCurrentMa(fullScaleCurrentMa), .smallTransistorSelect(smallTransistorSelect),
  .sink1Trim(sink1Trim), .sink2Trim(sink2Trim), .sink3Trim(sink3Trim), .sink4Trim(sink4Trim));
